// ### rtl/sac_pkg.sv
// Operation
// RULE1: converter runs only with power gate cleared
// RULE2: selections apply only while converter enabled
// RULE3: ten-bit code, zero ground, ones reference
// RULE4: right-justified result, left when adjust set
// RULE5: low read locks result until high read
// RULE6: done flag sets even if result discarded
// RULE7: start bit begins single conversion, self-clears
// RULE8: channel change waits for current conversion end
// RULE9: trigger rising edge resets prescaler, starts conversion
// RULE10: ignore busy edges and held trigger levels
// RULE11: trigger flags set regardless; software clears them
// RULE12: done-flag trigger runs free after first start
// RULE13: start bit reads busy; writable under auto
// RULE14: prescaler runs while enabled, reset otherwise
// RULE15: software start waits next adc clock edge
// RULE16: normal 15 cycles, first 26 cycles
// RULE17: sample at 4, or 15 when first
// RULE18: completion writes result, flags, clears start
// RULE19: triggered: half-cycle offset plus two syncs
// RULE20: free-running restarts at once, start stays high
// RULE21: gain active: changed selection uses first timing; code gives free-running restarts normal timing
// RULE22: software keeps adc clock 50-200 kHz
// RULE23: selection buffer locked from start to done
// RULE24: irq when done flag and enable set
package sac_pkg;
  localparam int ADDR_W = 5; // word-aligned byte address bits decoded
  // register byte addresses
  localparam logic [4:0] OFS_POWER = 5'h00; // power_reduction_reg
  localparam logic [4:0] OFS_CSA = 5'h04; // converter_ctrl_status_a
  localparam logic [4:0] OFS_CSB = 5'h08; // converter_ctrl_status_b
  localparam logic [4:0] OFS_CHAN = 5'h0c; // channel_select_reg
  localparam logic [4:0] OFS_REFG = 5'h10; // reference_gain_select_reg
  localparam logic [4:0] OFS_RES_LO = 5'h14; // result_low_byte
  localparam logic [4:0] OFS_RES_HI = 5'h18; // result_high_byte
  // control/status a fields
  localparam int CSA_EN = 7;
  localparam int CSA_START = 6;
  localparam int CSA_AUTO = 5;
  localparam int CSA_DONE = 4;
  localparam int CSA_IE = 3;
  // control/status b fields
  localparam int CSB_LEFT = 3;
  // reference/gain field positions
  localparam int REFG_REF_LSB = 5;
  localparam int REFG_REF_MSB = 7;
  localparam int REFG_GAIN_MSB = 1;
  localparam int CHAN_MSB = 5;
  localparam logic POWER_GATE_RST = 1'b1; // gated out of reset
  localparam logic [2:0] TRIG_SRC_DONE = 3'h0; // done flag as trigger
  // conversion timing, in adc clock cycles
  localparam logic [4:0] CONV_NORMAL = 5'h0f;
  localparam logic [4:0] CONV_FIRST = 5'h1a;
  localparam logic [4:0] SH_NORMAL = 5'h04;
  localparam logic [4:0] SH_FIRST = 5'h0f;
  localparam int RES_W = 10;
  typedef enum {ST_IDLE, ST_WAIT, ST_CONV} sac_state_t;
  // request bundle towards the analog core
  typedef struct packed {
    logic enable;
    logic sample;
    logic [5:0] channel;
    logic [2:0] reference;
    logic [1:0] gain;
  } sac_core_req_t;
endpackage

// ### rtl/sac_top.sv
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
  parameter int TRIG_W = 8 // number of trigger source inputs
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [sac_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [TRIG_W-1:0] trigger_in,
  input wire logic gain_active_in,
  input wire logic [sac_pkg::RES_W-1:0] core_result_in,
  output sac_pkg::sac_core_req_t core_req_out,
  output logic conversion_irq_out
);
  import sac_pkg::*;

  // prescaler divide ratio: 2, 2, 4 .. 128
  function automatic logic [7:0] div_of(input logic [2:0] ps);
    div_of = (ps == 3'h0) ? 8'h02 : 8'h01 << ps;
  endfunction

  // software visible state
  logic power_gate_q; // converter_power_gate
  logic enable_q; // converter_enable
  logic auto_q; // auto_trigger_enable
  logic done_q; // conversion_done_flag
  logic ie_q; // irq enable
  logic [2:0] ps_q; // prescaler_select
  logic left_q; // left_adjust_result
  logic [2:0] trig_sel_q; // trigger_source_select
  logic [5:0] chan_q; // input_channel_select
  logic [2:0] ref_q; // reference_select
  logic [1:0] gain_q; // gain_select
  logic [9:0] res_q; // latest kept result
  logic lock_q; // result bytes blocked after low read
  // selection buffer seen by the core
  logic [5:0] chan_buf_q;
  logic [2:0] ref_buf_q;
  logic [1:0] gain_buf_q;
  // conversion engine
  sac_state_t state_q;
  logic [7:0] pre_q; // prescaler count
  logic [4:0] cyc_q; // adc cycles into conversion
  logic [4:0] len_q; // length of running conversion
  logic [4:0] sh_q; // sample point of running conversion
  logic first_q; // next conversion is a first one
  logic half_q; // triggered start waits half adc clock
  logic trig_prev_q; // trigger level last cycle
  logic trig_edge_q; // second sync stage of trigger edge
  logic [10:0] conv_sel_q; // selection the last conversion begun from wait ran with
  // bus
  logic ack_q;
  logic [31:0] dat_q;
  sac_core_req_t req_q;
  logic irq_q;

  // bus decode, actions land on the edge that shows ack
  wire req_live = wb_cyc_in & wb_stb_in;
  wire acc = req_live & ack_q;
  wire wr = acc & wb_we_in & wb_sel_in[0];
  wire rd = acc & ~wb_we_in;
  wire wr_power = wr & (wb_adr_in == OFS_POWER);
  // gated converter is unclocked: its registers ignore writes [RULE1]
  wire live = ~power_gate_q;
  wire wr_csa = wr & live & (wb_adr_in == OFS_CSA);
  wire wr_csb = wr & live & (wb_adr_in == OFS_CSB);
  wire wr_chan = wr & live & (wb_adr_in == OFS_CHAN);
  wire wr_refg = wr & live & (wb_adr_in == OFS_REFG);
  wire rd_lo = rd & live & (wb_adr_in == OFS_RES_LO);
  wire rd_hi = rd & live & (wb_adr_in == OFS_RES_HI);
  wire [7:0] wdat = wb_dat_in[7:0];

  // converter runs only when enabled and ungated [RULE1] [RULE2]
  wire run = enable_q & live;
  wire busy = (state_q != ST_IDLE);

  // prescaler ticks
  wire [7:0] div = div_of(ps_q);
  wire tick = run & (pre_q == div - 8'h01);
  wire half_tick = run & (pre_q == (div >> 1) - 8'h01);

  // trigger source; index 0 follows the done flag
  wire [TRIG_W-1:0] trig_vec = {trigger_in[TRIG_W-1:1], done_q};
  wire trig_lvl = trig_vec[trig_sel_q];
  wire free_run = auto_q & (trig_sel_q == TRIG_SRC_DONE);
  // edge only, held level never retriggers [RULE10]
  wire trig_edge = trig_lvl & ~trig_prev_q;
  // synchronised edge starts when idle, busy edges dropped [RULE9] [RULE10] [RULE19]
  wire trig_start = run & auto_q & trig_edge_q & ~busy;
  // start bit write gives a single conversion, or free-running ones when auto uses the done flag [RULE7] [RULE13]
  // enable written in the same write counts, so enable plus start works at once
  wire sw_start = wr_csa & wdat[CSA_EN] & wdat[CSA_START] & ~busy;

  // conversion step
  wire conv_step = (state_q == ST_CONV) & tick;
  wire [4:0] cyc_next = cyc_q + 5'h01;
  wire sample_now = conv_step & (cyc_next == sh_q);
  wire complete = conv_step & (cyc_next == len_q);
  // triggered conversions start half an adc clock in [RULE19]
  wire begin_conv = (state_q == ST_WAIT) & (half_q ? half_tick : tick);

  // first timing after enable, or changed selection with gain on [RULE16] [RULE21]
  // buffer follows software while idle, so compare against the selection of the last conversion begun from wait
  wire [10:0] sel_now = {chan_buf_q, ref_buf_q, gain_buf_q};
  wire sel_changed = (sel_now != conv_sel_q);
  wire long_conv = first_q | (gain_active_in & sel_changed);

  // result justification [RULE3] [RULE4]
  wire [15:0] res_word = left_q ? {res_q, 6'h00} : {6'h00, res_q};

  // read mux
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (wb_adr_in)
      OFS_POWER: rmux = {7'h00, power_gate_q};
      // start bit reads as busy [RULE13]
      OFS_CSA: rmux = {enable_q, busy, auto_q, done_q, ie_q, ps_q};
      OFS_CSB: rmux = {4'h0, left_q, trig_sel_q};
      OFS_CHAN: rmux = {2'h0, chan_q};
      OFS_REFG: rmux = {ref_q, 3'h0, gain_q};
      OFS_RES_LO: rmux = res_word[7:0];
      OFS_RES_HI: rmux = res_word[15:8];
      default: rmux = 8'h00;
    endcase
  end

  // wishbone ack and read data, one cycle after request
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_live & ~ack_q;
      // gated converter registers read zero
      dat_q <= {24'h00_0000, (live | wb_adr_in == OFS_POWER) ? rmux : 8'h00};
    end
  end

  // power gate
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      power_gate_q <= POWER_GATE_RST;
    end else if (wr_power) begin
      power_gate_q <= wdat[0]; // [RULE1]
    end
  end

  // control fields
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      enable_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      left_q <= 1'b0;
      trig_sel_q <= 3'h0;
      chan_q <= 6'h00;
      ref_q <= 3'h0;
      gain_q <= 2'h0;
    end else begin
      if (wr_csa) begin
        enable_q <= wdat[CSA_EN];
        auto_q <= wdat[CSA_AUTO];
        ie_q <= wdat[CSA_IE];
        ps_q <= wdat[2:0];
      end
      if (wr_csb) begin
        left_q <= wdat[CSB_LEFT];
        trig_sel_q <= wdat[2:0];
      end
      if (wr_chan) begin
        chan_q <= wdat[CHAN_MSB:0];
      end
      if (wr_refg) begin
        ref_q <= wdat[REFG_REF_MSB:REFG_REF_LSB];
        gain_q <= wdat[REFG_GAIN_MSB:0];
      end
    end
  end

  // done flag: set by completion even if result dropped, set beats clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1; // [RULE6] [RULE18]
    end else if (wr_csa & wdat[CSA_DONE]) begin
      done_q <= 1'b0; // software clears with a one [RULE11]
    end
  end

  // result and read lock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      res_q <= 10'h000;
      lock_q <= 1'b0;
    end else begin
      // locked bytes discard the finishing result [RULE5]
      if (complete & ~lock_q) begin
        res_q <= core_result_in; // [RULE18]
      end
      if (rd_lo) begin
        lock_q <= 1'b1; // [RULE5]
      end else if (rd_hi) begin
        lock_q <= 1'b0; // [RULE5]
      end
    end
  end

  // selection buffer follows software except during a conversion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chan_buf_q <= 6'h00;
      ref_buf_q <= 3'h0;
      gain_buf_q <= 2'h0;
    end else if ((state_q != ST_CONV & ~begin_conv) | complete) begin
      chan_buf_q <= chan_q; // [RULE8] [RULE23]
      ref_buf_q <= ref_q;
      gain_buf_q <= gain_q;
    end
  end

  // prescaler, reset while off or on a trigger [RULE14] [RULE9]
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_q <= 8'h00;
    end else if (~run | trig_start | tick) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // trigger edge detect, then one more stage: two cpu cycles of sync
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trig_prev_q <= 1'b0;
      trig_edge_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_lvl;
      trig_edge_q <= trig_edge; // [RULE11]
    end
  end

  // selection captured as each conversion begins from wait; free-running restarts skip it [RULE21]
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      conv_sel_q <= '0;
    end else if (begin_conv) begin
      conv_sel_q <= sel_now;
    end
  end

  // first-conversion marker, rearmed whenever converter is off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      first_q <= 1'b1;
    end else if (~run) begin
      first_q <= 1'b1; // [RULE16]
    end else if (begin_conv) begin
      first_q <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cyc_q <= 5'h00;
      len_q <= CONV_NORMAL;
      sh_q <= SH_NORMAL;
      half_q <= 1'b0;
    end else if (~run & ~sw_start) begin
      state_q <= ST_IDLE; // off aborts any conversion [RULE2]
      half_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (sw_start) begin
            state_q <= ST_WAIT; // wait for next adc edge [RULE15]
            half_q <= 1'b0;
          end else if (trig_start) begin
            state_q <= ST_WAIT; // [RULE9] [RULE19]
            half_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (begin_conv) begin
            state_q <= ST_CONV;
            cyc_q <= 5'h00;
            len_q <= long_conv ? CONV_FIRST : CONV_NORMAL; // [RULE16] [RULE21]
            sh_q <= long_conv ? SH_FIRST : SH_NORMAL; // [RULE17]
          end
        end
        ST_CONV: begin
          if (complete & free_run) begin
            state_q <= ST_CONV; // restart at once, start stays high [RULE12] [RULE20]
            cyc_q <= 5'h00;
            len_q <= CONV_NORMAL;
            sh_q <= SH_NORMAL;
          end else if (complete) begin
            state_q <= ST_IDLE; // start bit clears with the flag [RULE7] [RULE18]
          end else if (conv_step) begin
            cyc_q <= cyc_next;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // core request: selections only reach the core while enabled [RULE2]
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_q <= '0;
    end else begin
      req_q.enable <= run;
      req_q.sample <= sample_now; // [RULE17]
      req_q.channel <= run ? chan_buf_q : 6'h00;
      req_q.reference <= run ? ref_buf_q : 3'h0;
      req_q.gain <= run ? gain_buf_q : 2'h0;
    end
  end

  // interrupt request [RULE24]
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_q & ie_q;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;
  assign core_req_out = req_q;
  assign conversion_irq_out = irq_q;
endmodule // sac_top
`default_nettype wire

// ### verification/sac_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
  import sac_pkg::*;
(
  input wire logic clk_in,
  input wire sac_core_req_t req_in,
  output logic [RES_W-1:0] result_out
);
  logic [RES_W-1:0] held_q; // code held since sample-and-hold
  // capture at the sample pulse; the code carries the channel
  always_ff @(posedge clk_in) begin
    if (req_in.sample) begin
      held_q <= {4'ha, req_in.channel};
    end else if (!req_in.enable) begin
      held_q <= ~held_q; // unpowered core: no stable code
    end
  end
  assign result_out = held_q;
endmodule // sac_core_model
`default_nettype wire

// ### verification/sac_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_asserts
  import sac_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire sac_core_req_t core_req_out,
  input wire logic conversion_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // bus answers one cycle after a request
  a_ack_follows_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 5'h1c |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  // sample pulses are single and far apart
  a_sample_spacing: assert property (core_req_out.sample |=> !core_req_out.sample [*8])
    else $error("sample pulses too close");
  a_sample_enabled: assert property (core_req_out.sample |-> core_req_out.enable)
    else $error("sample while disabled");
  a_off_no_select: assert property (!core_req_out.enable |->
    {core_req_out.channel, core_req_out.reference, core_req_out.gain} == 11'h000)
    else $error("selection applied while off");
  a_select_held: assert property (core_req_out.sample |-> $stable(core_req_out.channel))
    else $error("channel moved in conversion");
  a_quiet_after_reset: assert property ($rose(rst_n_in) |-> !wb_ack_out && core_req_out == '0)
    else $error("outputs busy after reset");
  c_sample: cover property (core_req_out.sample);
  c_irq: cover property ($rose(conversion_irq_out));
  c_unmapped: cover property (wb_ack_out && wb_adr_in == 5'h1c);
endmodule // sac_top_asserts
bind sac_top sac_top_asserts u_chk (.clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_dat_out, .wb_ack_out, .core_req_out, .conversion_irq_out);
`default_nettype wire

// ### verification/sac_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb_top;
  import sac_pkg::*;
  logic clk_in = 1'b0; // 25 MHz
  logic rst_n_in = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] r; // last read data
  logic ack;
  logic irq;
  logic [7:0] trig = 8'h00; // trigger levels
  logic gain = 1'b0; // gain amplifier active
  logic [RES_W-1:0] core_res;
  sac_core_req_t req;
  int err_total = 0;
  int comparisons = 0;
  int n;
  always #20 clk_in = ~clk_in;
  sac_top u_dut (.clk_in, .rst_n_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'h1), .wb_dat_in(dat_i), .wb_dat_out(dat_o), .wb_ack_out(ack), .trigger_in(trig),
    .gain_active_in(gain), .core_result_in(core_res), .core_req_out(req), .conversion_irq_out(irq));
  sac_core_model u_core (.clk_in, .req_in(req), .result_out(core_res));
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fail_out;
    err_total++;
    tally_and_finish();
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) fail_out();
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in); // idle gap
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(r, exp);
  endtask
  // cycles until the next sample pulse
  task automatic wsamp;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (req.sample !== 1'b1 && n < 2000);
    if (req.sample !== 1'b1) fail_out();
  endtask
  // poll the busy bit until it drops
  task automatic wdone;
    int k;
    for (k = 0; k < 100; k++) begin
      bus(1'b0, OFS_CSA, 8'h00);
      if (r[CSA_START] === 1'b0) break;
    end
    if (r[CSA_START] !== 1'b0) fail_out();
  endtask
  task automatic s_gate;
    bus(1'b1, OFS_CSA, 8'h80);
    rd_chk(OFS_CSA, 32'h0);
    rd_chk(5'h1c, 32'h0);
    bus(1'b1, OFS_POWER, 8'h00);
    rd_chk(OFS_CSA, 32'h0);
  endtask
  task automatic s_single;
    bus(1'b1, OFS_CHAN, 8'h05);
    bus(1'b1, OFS_CSA, 8'hc8); // enable, start, irq on, divide by 2
    rd_chk(OFS_CSA, 32'hc8);
    bus(1'b1, OFS_CHAN, 8'h09); // change while converting
    wsamp();
    chk(n > 18, 1'b1);
    wdone();
    chk(irq, 1'b1);
    rd_chk(OFS_CSA, 32'h98);
    rd_chk(OFS_RES_LO, 32'h85);
    rd_chk(OFS_RES_HI, 32'h02);
    bus(1'b1, OFS_CSA, 8'hd8); // restart, clear done
    wsamp();
    chk(n < 14, 1'b1);
    wdone();
    rd_chk(OFS_RES_LO, 32'h89);
    rd_chk(OFS_RES_HI, 32'h02);
  endtask
  task automatic s_lock;
    rd_chk(OFS_RES_LO, 32'h89); // low read locks the pair
    bus(1'b1, OFS_CHAN, 8'h03);
    bus(1'b1, OFS_CSA, 8'hdb); // divide by 8
    wsamp();
    chk(n > 24, 1'b1);
    wdone();
    rd_chk(OFS_CSA, 32'h9b);
    rd_chk(OFS_RES_HI, 32'h02);
    rd_chk(OFS_RES_LO, 32'h89);
    rd_chk(OFS_RES_HI, 32'h02);
    bus(1'b1, OFS_CSB, 8'h08); // left adjust
    bus(1'b1, OFS_CSA, 8'hd8);
    wdone();
    rd_chk(OFS_RES_LO, 32'hc0);
    rd_chk(OFS_RES_HI, 32'ha0);
  endtask
  // gain active: changed channel gets long timing, repeat gets normal
  task automatic s_gain;
    gain <= 1'b1;
    bus(1'b1, OFS_CHAN, 8'h07);
    bus(1'b1, OFS_CSA, 8'hd8);
    wsamp();
    chk(n > 18, 1'b1);
    wdone();
    bus(1'b1, OFS_CSA, 8'hd8);
    wsamp();
    chk(n < 14, 1'b1);
    wdone();
    gain <= 1'b0;
  endtask
  task automatic s_free;
    bus(1'b1, OFS_CSB, 8'h00); // done flag as trigger
    bus(1'b1, OFS_CSA, 8'hf8);
    wsamp();
    wsamp();
    wsamp(); // restarts with no software help
    rd_chk(OFS_CSA, 32'hf8);
    bus(1'b1, OFS_CSA, 8'h10); // off, clear done
  endtask
  task automatic s_trig;
    bus(1'b1, OFS_CSB, 8'h01);
    bus(1'b1, OFS_CSA, 8'ha8); // enable, auto, no start
    trig <= 8'h02;
    wsamp();
    wdone();
    rd_chk(OFS_CSA, 32'hb8);
    n = 0;
    repeat (150) begin
      @(posedge clk_in);
      if (req.sample !== 1'b0) n++;
    end
    chk(n, 32'h0);
    bus(1'b1, OFS_CSA, 8'hef); // software start under auto, divide by 128
    wsamp();
    trig <= 8'h00;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    s_gate();
    s_single();
    s_lock();
    s_gain();
    s_free();
    s_trig();
    tally_and_finish();
  end
endmodule // sac_top_tb_top
`default_nettype wire
